//--- common/spr_pkg.sv
// Purpose: constants and types for the serial-link pll control register bank
// Assumes: byte-wide registers reached through the serial register port
// Notes: addresses are the 15-bit register addresses used on the port
// Contract
// [RULE1] equalizer power field: 00 normal, 01 low power
// [RULE2] software keeps equalizer reserved bits at 0x22
// [RULE3] recalibrate bit rising edge starts pll calibration
// [RULE4] setting pll enable turns pll on, calibrates
// [RULE5] status bits 5/4 report charge pump overrange
// [RULE6] status bit 3 high after successful calibration
// [RULE7] status bit 2 high while calibration runs
// [RULE8] status bit 1 high once bias currents ready
// [RULE9] status bit 0 lock; status read-only, resets zero
// [RULE10] software keeps divider upper bits at one
// [RULE11] divider code 00/01/10 divides by 4/2/1
// [RULE12] software keeps divided reference within 35-80 MHz
// [RULE13] divider choice follows the lane rate bands
// [RULE14] termination bit rising edge starts termination calibration
// [RULE15] checksum mode selects field sum or packed-register sum
// [RULE16] per-lane computed checksum readable in result registers
// [RULE17] software enables link only after calibration finishes
// [RULE18] software polls lock and calibration-good before use
package spr_pkg;

    localparam int unsigned ADDR_W        = 15;
    localparam int unsigned INSTR_BITS    = 16;
    localparam int unsigned LANES         = 4;
    localparam int unsigned CFG_BYTES     = 13;

    localparam logic [14:0] EQ_BIAS_ADDR   = 15'h0268;
    localparam logic [14:0] PLL_EN_ADDR    = 15'h0280;
    localparam logic [14:0] PLL_STAT_ADDR  = 15'h0281;
    localparam logic [14:0] REF_DIV_ADDR   = 15'h0289;
    localparam logic [14:0] TERM_CAL_ADDR  = 15'h02a7;
    localparam logic [14:0] RX_GEN_ADDR    = 15'h0300;
    localparam logic [14:0] SUM_BASE_ADDR  = 15'h040e;
    localparam logic [14:0] SUM_STRIDE     = 15'h0008;

    localparam logic [7:0] EQ_BIAS_RESET   = 8'h62;
    localparam logic [7:0] PLL_EN_RESET    = 8'h00;
    localparam logic [7:0] REF_DIV_RESET   = 8'h04;

    localparam int unsigned PLL_EN_BIT     = 0;
    localparam int unsigned RECAL_BIT      = 2;
    localparam int unsigned TERM_CAL_BIT   = 0;
    localparam int unsigned CHK_MODE_BIT   = 6;
    localparam int unsigned ST_CP_HIGH     = 5;
    localparam int unsigned ST_CP_LOW      = 4;
    localparam int unsigned ST_CAL_GOOD    = 3;
    localparam int unsigned ST_CAL_RUN     = 2;
    localparam int unsigned ST_BIAS_OK     = 1;
    localparam int unsigned ST_LOCK        = 0;

    localparam logic [1:0] EQ_POWER_NORMAL = 2'h0;
    localparam logic [1:0] EQ_POWER_LOW    = 2'h1;
    localparam logic [1:0] DIV_BY_4        = 2'h0;
    localparam logic [1:0] DIV_BY_2        = 2'h1;
    localparam logic [1:0] DIV_BY_1        = 2'h2;

    // lane identity position inside the packed configuration bytes
    localparam int unsigned LID_BYTE       = 2;

    typedef enum logic {
        SPR_SPI_INSTR,
        SPR_SPI_DATA
    } spr_spi_state_t;

    typedef enum logic {
        SPR_CAL_IDLE,
        SPR_CAL_RUN
    } spr_cal_state_t;

endpackage

//--- hw/spr_checksum.sv
// Purpose: per-lane link parameter checksum, two selectable methods
// Assumes: packed configuration bytes 0..12 common to all lanes except lane id
// Notes: combinational; the register bank registers the results
`timescale 1ns/1ps
module spr_checksum (
    input  wire logic [8*spr_pkg::CFG_BYTES-1:0] cfg_packed,
    input  wire logic [5*spr_pkg::LANES-1:0]     lane_ids,
    input  wire logic                            checksum_mode,
    output logic      [8*spr_pkg::LANES-1:0]     sums
);

    genvar ln;
    generate
        for (ln = 0; ln < spr_pkg::LANES; ln = ln + 1) begin : g_lane
            logic [7:0] b [0:spr_pkg::CFG_BYTES-1];
            logic [7:0] packed_sum;
            logic [7:0] field_sum;
            genvar bi;
            for (bi = 0; bi < spr_pkg::CFG_BYTES; bi = bi + 1) begin : g_byte
                if (bi == spr_pkg::LID_BYTE) begin : g_lid
                    assign b[bi] = {cfg_packed[8*bi+7:8*bi+5], lane_ids[5*ln+4:5*ln]};
                end else begin : g_plain
                    assign b[bi] = cfg_packed[8*bi+7:8*bi];
                end
            end

            always_comb begin
                packed_sum = 8'h00;
                for (int i = 0; i < spr_pkg::CFG_BYTES; i++) begin
                    packed_sum = packed_sum + b[i];
                end
            end

            // fields summed individually, each zero extended, result mod 256
            always_comb begin
                field_sum = b[0]
                    + {4'h0, b[1][7:4]} + {4'h0, b[1][3:0]}
                    + {7'h00, b[2][6]} + {7'h00, b[2][5]} + {3'h0, b[2][4:0]}
                    + {7'h00, b[3][7]} + {3'h0, b[3][4:0]}
                    + b[4] + {3'h0, b[5][4:0]} + b[6]
                    + {6'h00, b[7][7:6]} + {3'h0, b[7][4:0]}
                    + {5'h00, b[8][7:5]} + {3'h0, b[8][4:0]}
                    + {5'h00, b[9][7:5]} + {3'h0, b[9][4:0]}
                    + {7'h00, b[10][7]} + {3'h0, b[10][4:0]};
            end

            assign sums[8*ln+7:8*ln] = checksum_mode ? packed_sum : field_sum; // see [RULE15]
        end
    endgenerate

endmodule

//--- hw/spr_pll_regs.sv
// Purpose: serial-port register bank for the serial-link pll and termination
// Assumes: port pins and analog status inputs synchronous to clk
// Notes: instruction is 16 bits (read flag then 15-bit address), data msb first,
//        address increments after each byte while the port stays selected
`timescale 1ns/1ps
module spr_pll_regs (
    input  wire logic                            clk,
    input  wire logic                            rstn,
    input  wire logic                            spi_sclk,
    input  wire logic                            spi_cs_n,
    input  wire logic                            spi_sdi,
    output logic                                 spi_sdo,
    output logic                                 spi_sdo_en_n,
    input  wire logic                            pll_locked_in,
    input  wire logic                            pll_bias_in,
    input  wire logic                            cp_high_in,
    input  wire logic                            cp_low_in,
    input  wire logic                            pll_cal_done,
    input  wire logic [8*spr_pkg::CFG_BYTES-1:0] cfg_packed,
    input  wire logic [5*spr_pkg::LANES-1:0]     lane_ids,
    output logic      [1:0]                      equalizer_power_select,
    output logic      [5:0]                      eq_bias_trim,
    output logic                                 pll_enable_bit,
    output logic                                 pll_cal_start,
    output logic      [1:0]                      reference_divide_select,
    output logic      [5:0]                      ref_div_upper,
    output logic                                 termination_cal_trigger,
    output logic                                 checksum_mode,
    output logic      [8*spr_pkg::LANES-1:0]     computed_sum_result
);

    logic                   sclk_q;
    logic                   sclk_rise;
    logic                   sclk_fall;
    spr_pkg::spr_spi_state_t spi_state;
    logic [3:0]             bit_cnt;
    logic [15:0]            shift_in;
    logic                   rd_mode;
    logic [14:0]            cur_addr;
    logic [7:0]             rd_shift;
    logic [15:0]            next_instr;
    logic [14:0]            rd_addr;
    logic [7:0]             rd_data;
    logic                   wr_stb;
    logic [14:0]            wr_addr;
    logic [7:0]             wr_data;

    logic [7:0]             eq_bias_control;
    logic [7:0]             pll_enable_control;
    logic [7:0]             ref_div_control;
    logic                   term_cal_bit;
    logic [7:0]             pll_status;
    spr_pkg::spr_cal_state_t cal_state;
    logic                   cal_good;
    logic [8*spr_pkg::LANES-1:0] sums;

    assign sclk_rise  = spi_sclk & ~sclk_q;
    assign sclk_fall  = ~spi_sclk & sclk_q;
    assign next_instr = {shift_in[14:0], spi_sdi};

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            sclk_q <= 1'b0;
        end else begin
            sclk_q <= spi_sclk;
        end
    end

    // address for the byte about to be shifted out
    always_comb begin
        if (spi_state == spr_pkg::SPR_SPI_INSTR) begin
            rd_addr = next_instr[14:0];
        end else begin
            rd_addr = cur_addr + 15'h0001;
        end
    end

    always_comb begin
        rd_data = 8'h00;
        if (rd_addr == spr_pkg::EQ_BIAS_ADDR) begin
            rd_data = eq_bias_control;
        end else if (rd_addr == spr_pkg::PLL_EN_ADDR) begin
            rd_data = pll_enable_control;
        end else if (rd_addr == spr_pkg::PLL_STAT_ADDR) begin
            rd_data = pll_status; // see [RULE9]
        end else if (rd_addr == spr_pkg::REF_DIV_ADDR) begin
            rd_data = ref_div_control;
        end else if (rd_addr == spr_pkg::TERM_CAL_ADDR) begin
            rd_data = {7'h00, term_cal_bit};
        end else if (rd_addr == spr_pkg::RX_GEN_ADDR) begin
            rd_data = {1'b0, checksum_mode, 6'h00};
        end else begin
            for (int l = 0; l < spr_pkg::LANES; l++) begin
                if (rd_addr == spr_pkg::SUM_BASE_ADDR + 15'(l) * spr_pkg::SUM_STRIDE) begin
                    rd_data = computed_sum_result[8*l +: 8]; // see [RULE16]
                end
            end
        end
    end

    // serial port framing; deselect aborts any partial byte
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            spi_state <= spr_pkg::SPR_SPI_INSTR;
            bit_cnt   <= 4'h0;
            shift_in  <= 16'h0000;
            rd_mode   <= 1'b0;
            cur_addr  <= 15'h0000;
            rd_shift  <= 8'h00;
            wr_stb    <= 1'b0;
            wr_addr   <= 15'h0000;
            wr_data   <= 8'h00;
        end else begin
            wr_stb <= 1'b0;
            if (spi_cs_n) begin
                spi_state <= spr_pkg::SPR_SPI_INSTR;
                bit_cnt   <= 4'h0;
            end else if (sclk_rise) begin
                shift_in <= next_instr;
                bit_cnt  <= bit_cnt + 4'h1;
                case (spi_state)
                    spr_pkg::SPR_SPI_INSTR: begin
                        if (bit_cnt == 4'hf) begin
                            spi_state <= spr_pkg::SPR_SPI_DATA;
                            rd_mode   <= next_instr[15];
                            cur_addr  <= next_instr[14:0];
                            rd_shift  <= rd_data;
                            bit_cnt   <= 4'h0;
                        end
                    end
                    spr_pkg::SPR_SPI_DATA: begin
                        if (bit_cnt == 4'h7) begin
                            bit_cnt  <= 4'h0;
                            cur_addr <= cur_addr + 15'h0001;
                            rd_shift <= rd_data;
                            if (!rd_mode) begin
                                wr_stb  <= 1'b1;
                                wr_addr <= cur_addr;
                                wr_data <= next_instr[7:0];
                            end
                        end
                    end
                    default: begin
                        spi_state <= spr_pkg::SPR_SPI_INSTR;
                    end
                endcase
            end else if (sclk_fall && spi_state == spr_pkg::SPR_SPI_DATA && rd_mode) begin
                rd_shift <= {rd_shift[6:0], 1'b0};
            end
        end
    end

    // read data leaves on the falling edge so the host samples it on the rising one
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            spi_sdo      <= 1'b0;
            spi_sdo_en_n <= 1'b1;
        end else begin
            spi_sdo_en_n <= ~(~spi_cs_n && spi_state == spr_pkg::SPR_SPI_DATA && rd_mode);
            if (spi_cs_n) begin
                spi_sdo <= 1'b0;
            end else if (sclk_fall && spi_state == spr_pkg::SPR_SPI_DATA && rd_mode) begin
                spi_sdo <= rd_shift[7];
            end
        end
    end

    // control registers; reserved bits are stored as written except in the termination and checksum-mode registers
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            eq_bias_control    <= spr_pkg::EQ_BIAS_RESET;
            pll_enable_control <= spr_pkg::PLL_EN_RESET;
            ref_div_control    <= spr_pkg::REF_DIV_RESET;
            term_cal_bit       <= 1'b0;
            checksum_mode      <= 1'b0;
        end else if (wr_stb) begin
            if (wr_addr == spr_pkg::EQ_BIAS_ADDR) begin
                eq_bias_control <= wr_data; // see [RULE1]
            end else if (wr_addr == spr_pkg::PLL_EN_ADDR) begin
                pll_enable_control <= wr_data;
            end else if (wr_addr == spr_pkg::REF_DIV_ADDR) begin
                ref_div_control <= wr_data; // see [RULE11]
            end else if (wr_addr == spr_pkg::TERM_CAL_ADDR) begin
                term_cal_bit <= wr_data[spr_pkg::TERM_CAL_BIT];
            end else if (wr_addr == spr_pkg::RX_GEN_ADDR) begin
                checksum_mode <= wr_data[spr_pkg::CHK_MODE_BIT]; // see [RULE15]
            end
        end
    end

    assign equalizer_power_select  = eq_bias_control[7:6];
    assign eq_bias_trim            = eq_bias_control[5:0];
    assign pll_enable_bit          = pll_enable_control[spr_pkg::PLL_EN_BIT];
    assign reference_divide_select = ref_div_control[1:0];
    assign ref_div_upper           = ref_div_control[7:2];

    // one-cycle start pulses on a written 0-to-1 change; steady levels do nothing
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pll_cal_start           <= 1'b0;
            termination_cal_trigger <= 1'b0;
        end else begin
            pll_cal_start <= wr_stb && wr_addr == spr_pkg::PLL_EN_ADDR
                && ((wr_data[spr_pkg::RECAL_BIT] && !pll_enable_control[spr_pkg::RECAL_BIT]) // see [RULE3]
                 || (wr_data[spr_pkg::PLL_EN_BIT] && !pll_enable_control[spr_pkg::PLL_EN_BIT])); // see [RULE4]
            termination_cal_trigger <= wr_stb && wr_addr == spr_pkg::TERM_CAL_ADDR
                && wr_data[spr_pkg::TERM_CAL_BIT] && !term_cal_bit; // see [RULE14]
        end
    end

    // calibration tracker; a new start wins over a done in the same cycle
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cal_state <= spr_pkg::SPR_CAL_IDLE;
            cal_good  <= 1'b0;
        end else if (!pll_enable_bit) begin
            cal_state <= spr_pkg::SPR_CAL_IDLE;
            cal_good  <= 1'b0;
        end else if (pll_cal_start) begin
            cal_state <= spr_pkg::SPR_CAL_RUN;
            cal_good  <= 1'b0;
        end else begin
            case (cal_state)
                spr_pkg::SPR_CAL_RUN: begin
                    if (pll_cal_done) begin
                        cal_state <= spr_pkg::SPR_CAL_IDLE;
                        cal_good  <= 1'b1; // see [RULE6]
                    end
                end
                default: begin
                    cal_state <= spr_pkg::SPR_CAL_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pll_status <= 8'h00;
        end else begin
            pll_status <= 8'h00;
            pll_status[spr_pkg::ST_CP_HIGH]  <= cp_high_in; // see [RULE5]
            pll_status[spr_pkg::ST_CP_LOW]   <= cp_low_in; // see [RULE5]
            pll_status[spr_pkg::ST_CAL_GOOD] <= cal_good; // see [RULE6]
            pll_status[spr_pkg::ST_CAL_RUN]  <= cal_state == spr_pkg::SPR_CAL_RUN; // see [RULE7]
            pll_status[spr_pkg::ST_BIAS_OK]  <= pll_bias_in; // see [RULE8]
            pll_status[spr_pkg::ST_LOCK]     <= pll_locked_in; // see [RULE9]
        end
    end

    spr_checksum u_checksum (
        .cfg_packed    (cfg_packed),
        .lane_ids      (lane_ids),
        .checksum_mode (checksum_mode),
        .sums          (sums)
    );

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            computed_sum_result <= '0;
        end else begin
            computed_sum_result <= sums; // see [RULE16]
        end
    end

endmodule

//--- testbench/spr_pll_regs_props.sv
// Purpose: concurrent checks on the pll control register bank ports
// Assumes: single clock domain, asynchronous active-low reset
// Notes: port writes commit within four idle cycles of the final data bit
`timescale 1ns/1ps
module spr_pll_regs_props (
    input wire logic                            clk,
    input wire logic                            rstn,
    input wire logic                            spi_cs_n,
    input wire logic [8*spr_pkg::CFG_BYTES-1:0] cfg_packed,
    input wire logic [5*spr_pkg::LANES-1:0]     lane_ids,
    input wire logic [1:0]                      equalizer_power_select,
    input wire logic                            pll_enable_bit,
    input wire logic                            pll_cal_start,
    input wire logic [1:0]                      reference_divide_select,
    input wire logic [5:0]                      ref_div_upper,
    input wire logic                            termination_cal_trigger,
    input wire logic                            checksum_mode,
    input wire logic [8*spr_pkg::LANES-1:0]     computed_sum_result
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    logic [7:0] e0;
    logic [7:0] e3;
    function automatic logic [7:0] psum(input logic [103:0] c, input logic [4:0] id);
        logic [7:0] s;
        s = {c[23:21], id};
        for (int i = 0; i < 13; i++) if (i != 2) s += c[8*i+:8];
        return s;
    endfunction
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            e0 <= 8'h00;
            e3 <= 8'h00;
        end else begin
            e0 <= psum(cfg_packed, lane_ids[4:0]);
            e3 <= psum(cfg_packed, lane_ids[19:15]);
        end
    end
    // port deselected long enough that no write can still be landing
    sequence sel_idle;
        spi_cs_n [*4];
    endsequence
    sequence en_rise;
        $rose(pll_enable_bit);
    endsequence
    AST_CAL_PULSE: assert property (pll_cal_start |=> !pll_cal_start)
        else $error("cal start wider than one cycle");
    AST_CAL_ON_ENABLE: assert property (en_rise |-> pll_cal_start)
        else $error("enable did not start calibration");
    AST_NO_CAL_IDLE: assert property (sel_idle |-> !pll_cal_start)
        else $error("calibration started without a write");
    AST_TERM_PULSE: assert property (termination_cal_trigger |=> !termination_cal_trigger)
        else $error("termination trigger wider than one cycle");
    AST_NO_TERM_IDLE: assert property (sel_idle |-> !termination_cal_trigger)
        else $error("termination started without a write");
    AST_EQ_HOLD: assert property (sel_idle |-> $stable(equalizer_power_select))
        else $error("equalizer power changed while idle");
    AST_DIV_HOLD: assert property (sel_idle |-> $stable(reference_divide_select))
        else $error("divider changed while idle");
    AST_UPPER_HOLD: assert property (sel_idle |-> $stable(ref_div_upper))
        else $error("divider upper bits changed while idle");
    AST_SUM_LANE0: assert property ($past(checksum_mode) |-> computed_sum_result[7:0] == e0)
        else $error("lane 0 packed checksum wrong");
    AST_SUM_LANE3: assert property ($past(checksum_mode) |-> computed_sum_result[31:24] == e3)
        else $error("lane 3 packed checksum wrong");
endmodule
bind spr_pll_regs spr_pll_regs_props u_props (.clk(clk), .rstn(rstn), .spi_cs_n(spi_cs_n),
    .cfg_packed(cfg_packed), .lane_ids(lane_ids), .equalizer_power_select(equalizer_power_select),
    .pll_enable_bit(pll_enable_bit), .pll_cal_start(pll_cal_start),
    .reference_divide_select(reference_divide_select), .ref_div_upper(ref_div_upper),
    .termination_cal_trigger(termination_cal_trigger), .checksum_mode(checksum_mode),
    .computed_sum_result(computed_sum_result));

//--- testbench/serdes_pll_control_regs_tb.sv
// Purpose: directed register-port tests of the pll control register bank
// Assumes: port clock levels last at least two clk cycles
// Notes: one byte per select frame; pulse outputs are counted
`timescale 1ns/1ps
module serdes_pll_control_regs_tb;
    localparam logic [103:0] CFG = 104'h0123456789abcdeffedcba9876;
    localparam logic [19:0]  LID = {5'h11, 5'h07, 5'h1a, 5'h05};
    logic clk = 0, rstn = 0, spi_sclk = 0, spi_cs_n = 1, spi_sdi = 0;
    logic lk = 0, bs = 0, ch = 0, cl = 0, done = 0;
    logic spi_sdo, spi_sdo_en_n, pen, pcs, tct, cm;
    logic [1:0] eps, rds;
    logic [5:0] ebt, rdu;
    logic [31:0] csr;
    logic [7:0] q;
    logic en;
    int mismatches = 0, tests_run = 0, cal_n = 0, term_n = 0;
    logic [14:0] ra [6] = '{15'h268, 15'h280, 15'h281, 15'h289, 15'h2a7, 15'h300};
    logic [7:0]  rv [6] = '{8'h62, 8'h00, 8'h00, 8'h04, 8'h00, 8'h00};
    spr_pll_regs DUT (.clk(clk), .rstn(rstn), .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n), .spi_sdi(spi_sdi),
        .spi_sdo(spi_sdo), .spi_sdo_en_n(spi_sdo_en_n), .pll_locked_in(lk), .pll_bias_in(bs),
        .cp_high_in(ch), .cp_low_in(cl), .pll_cal_done(done), .cfg_packed(CFG), .lane_ids(LID),
        .equalizer_power_select(eps), .eq_bias_trim(ebt), .pll_enable_bit(pen), .pll_cal_start(pcs),
        .reference_divide_select(rds), .ref_div_upper(rdu), .termination_cal_trigger(tct),
        .checksum_mode(cm), .computed_sum_result(csr));
    initial forever #10 clk = ~clk;
    always @(posedge clk) begin
        if (pcs === 1'b1) cal_n++;
        if (tct === 1'b1) term_n++;
    end
    task automatic wt(input int n);
        repeat (n) @(posedge clk);
        #2;
    endtask
    task automatic close_out;
        if (mismatches == 0 && tests_run > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // sdi set with the fall, held through the rise; sdo read just before the rise
    task automatic spi(input logic r, input logic [14:0] a, input logic [7:0] d);
        logic [23:0] sh;
        sh = {r, a, d};
        spi_cs_n = 0;
        for (int i = 23; i >= 0; i--) begin
            spi_sdi = sh[i];
            spi_sclk = 0;
            wt(3);
            if (i < 8) q[i] = spi_sdo;
            if (i == 0) en = spi_sdo_en_n;
            spi_sclk = 1;
            wt(2);
        end
        spi_sclk = 0;
        wt(4);
        spi_cs_n = 1;
        // long enough deselect for the idle-hold checks to see it
        wt(6);
    endtask
    task automatic wr(input logic [14:0] a, input logic [7:0] d);
        spi(1'b0, a, d);
        chk({7'h00, en}, 8'h01);
    endtask
    task automatic rd(input logic [14:0] a, input logic [7:0] e);
        spi(1'b1, a, 8'h00);
        chk(q, e);
        chk({7'h00, en}, 8'h00);
    endtask
    function automatic logic [7:0] csum(input logic [4:0] id);
        logic [7:0] s;
        s = {CFG[23:21], id};
        for (int i = 0; i < 13; i++) if (i != 2) s += CFG[8*i+:8];
        return s;
    endfunction
    // individual link fields of bytes 0..10 summed, lane id in byte 2
    function automatic logic [7:0] fsum(input logic [4:0] id);
        logic [103:0] c;
        c = CFG;
        c[20:16] = id;
        return c[7:0] + c[15:12] + c[11:8] + c[22] + c[21] + c[20:16] + c[31] + c[28:24]
            + c[39:32] + c[44:40] + c[55:48] + c[63:62] + c[60:56] + c[71:69] + c[68:64]
            + c[79:77] + c[76:72] + c[87] + c[84:80];
    endfunction
    initial begin
        repeat (20000) @(posedge clk);
        mismatches++;
        close_out();
    end
    initial begin
        wt(6);
        rstn = 1;
        wt(2);
        chk({6'h00, eps}, 8'h01);
        chk({2'h0, ebt}, 8'h22);
        for (int i = 0; i < 6; i++) rd(ra[i], rv[i]);
        wr(15'h268, 8'h22);
        chk({6'h00, eps}, 8'h00);
        rd(15'h268, 8'h22);
        for (int c = 2; c >= 0; c--) begin
            wr(15'h289, {6'h01, 2'(c)});
            chk({6'h00, rds}, 8'(c));
            chk({2'h0, rdu}, 8'h01);
        end
        wr(15'h280, 8'h01);
        chk(8'(cal_n), 8'h01);
        chk({7'h00, pen}, 8'h01);
        rd(15'h281, 8'h04);
        done = 1;
        wt(1);
        done = 0;
        rd(15'h281, 8'h08);
        wr(15'h280, 8'h01);
        chk(8'(cal_n), 8'h01);
        wr(15'h280, 8'h05);
        chk(8'(cal_n), 8'h02);
        wr(15'h280, 8'h05);
        chk(8'(cal_n), 8'h02);
        wr(15'h280, 8'h00);
        chk({7'h00, pen}, 8'h00);
        rd(15'h281, 8'h00);
        {lk, bs, ch, cl} = 4'b1110;
        rd(15'h281, 8'h23);
        {lk, bs, ch, cl} = 4'b0101;
        wr(15'h281, 8'hff);
        rd(15'h281, 8'h12);
        wr(15'h2a7, 8'hff);
        chk(8'(term_n), 8'h01);
        rd(15'h2a7, 8'h01);
        wr(15'h2a7, 8'h01);
        chk(8'(term_n), 8'h01);
        rd(15'h40e, fsum(LID[4:0]));
        wr(15'h300, 8'hff);
        chk({7'h00, cm}, 8'h01);
        rd(15'h300, 8'h40);
        rd(15'h40e, csum(LID[4:0]));
        wr(15'h40e, 8'h00);
        rd(15'h40e, csum(LID[4:0]));
        rd(15'h426, csum(LID[19:15]));
        rd(15'h2ff, 8'h00);
        close_out();
    end
endmodule
